// ### include/uhf_consts.vh
`ifndef UHF_CONSTS_VH
`define UHF_CONSTS_VH

// Register offsets on the host parallel bus.
`define UHF_ADDR_INTERRUPT_ENABLE 3'h1
`define UHF_ADDR_FIFO_CONTROL 3'h2
`define UHF_ADDR_INTERRUPT_IDENTIFY 3'h2

// Interrupt enable fields.
`define UHF_IE_RX_DATA 0
`define UHF_IE_TX_EMPTY 1
`define UHF_IE_LINE_STATUS 2
`define UHF_IE_MODEM_STATUS 3
`define UHF_IE_RESET 4'h0

// FIFO control fields.
`define UHF_FC_ENABLE 0
`define UHF_FC_RX_RESET 1
`define UHF_FC_TX_RESET 2
`define UHF_FC_DMA 3
`define UHF_FC_TRIG_LSB 6
`define UHF_FC_TRIG_MSB 7
`define UHF_TRIG_RESET 2'h0

// Receive trigger levels in bytes.
`define UHF_TRIG_LEVEL_0 5'h01
`define UHF_TRIG_LEVEL_1 5'h04
`define UHF_TRIG_LEVEL_2 5'h08
`define UHF_TRIG_LEVEL_3 5'h0E

// Identification codes placed in bits 3 to 1.
`define UHF_ID_LINE_STATUS 3'h3
`define UHF_ID_RX_DATA 3'h2
`define UHF_ID_CHAR_TIMEOUT 3'h6
`define UHF_ID_TX_EMPTY 3'h1
`define UHF_ID_MODEM_STATUS 3'h0
`define UHF_ID_NONE 3'h0

// Character times without receive activity before a timeout.
`define UHF_TIMEOUT_CHARS 3'h4

`endif

// ### design/uhf_char_timeout.v
`timescale 1ns/100ps
`include "uhf_consts.vh"

module uhf_char_timeout (
   // Clock and reset.
   input wire i_clk,
   input wire i_reset,
   // Receive FIFO activity.
   input wire i_fifo_mode,
   input wire i_rx_nonempty,
   input wire i_rx_activity,
   input wire i_char_tick,
   // Timeout indication.
   output reg o_timeout
);

   reg [2:0] char_count;

   // Any push or pop restarts the count, so the flag drops with the next activity.
   always @(posedge i_clk) begin
      if (i_reset || !i_fifo_mode || !i_rx_nonempty || i_rx_activity) begin
         char_count <= 3'h0;
         o_timeout <= 1'b0;
      end else if (i_char_tick && !o_timeout) begin
         char_count <= char_count + 3'h1;
         if (char_count + 3'h1 == `UHF_TIMEOUT_CHARS) begin
            o_timeout <= 1'b1;
         end
      end
   end

endmodule

// ### design/uhf_host_int_fifo_ctrl.v
`timescale 1ns/100ps
`include "uhf_consts.vh"

module uhf_host_int_fifo_ctrl #(
   parameter FIFO_DEPTH = 16,
   parameter COUNT_W = 5
) (
   // Clock and reset.
   input wire i_clk,
   input wire i_reset,
   // Host register bus, synchronous to i_clk.
   input wire [2:0] i_host_addr,
   input wire i_host_cs,
   input wire i_host_rd,
   input wire i_host_wr,
   input wire [7:0] i_host_wdata,
   input wire i_divisor_access_select,
   output reg [7:0] o_host_rdata,
   output reg o_host_rdata_sel,
   // Line and modem status from the serial logic.
   input wire [5:0] i_line_status,
   input wire i_line_status_read,
   input wire [3:0] i_modem_status,
   // Receive FIFO state.
   input wire [COUNT_W-1:0] i_rx_count,
   input wire i_rx_push,
   input wire i_rx_pop,
   input wire i_char_tick,
   // Transmit FIFO state.
   input wire [COUNT_W-1:0] i_tx_count,
   input wire i_tx_write,
   // Host interrupt and DMA requests.
   output reg o_host_interrupt_out,
   output reg o_receive_dma_request,
   output reg o_transmit_dma_request,
   // FIFO control towards the datapath.
   output reg o_fifo_enable,
   output reg o_dma_mode,
   output reg [1:0] o_rx_trigger_sel,
   output reg o_rx_fifo_clear,
   output reg o_tx_fifo_clear
);

   localparam [COUNT_W-1:0] FULL_COUNT = FIFO_DEPTH[COUNT_W-1:0];

   reg [3:0] interrupt_enable;
   reg wr_q;
   reg rd_q;
   reg [3:0] line_err_q;
   reg thre_q;
   reg pend_line;
   reg pend_tx;
   reg id_tx_reported;
   reg char_timeout_q;
   reg ident_read_q;
   reg [2:0] frozen_id;
   reg frozen_none;

   wire char_timeout;
   wire wr_take;
   wire rd_take;
   wire ident_read;
   wire ident_read_end;
   wire ie_sel;
   wire fc_write;
   wire ie_write;
   wire rx_nonempty;
   wire tx_empty;
   wire tx_full;
   wire rx_at_trigger;
   wire line_change;
   wire thre_rise;
   wire src_line;
   wire src_rx;
   wire src_timeout;
   wire src_tx;
   wire src_modem;
   wire any_pending;
   reg [4:0] trigger_bytes;
   reg [2:0] next_id;
   reg next_rx_dma;
   reg next_tx_dma;

   assign wr_take = i_host_cs && i_host_wr && !wr_q;
   assign rd_take = i_host_cs && i_host_rd && !rd_q;
   assign ident_read = i_host_cs && i_host_rd && (i_host_addr == `UHF_ADDR_INTERRUPT_IDENTIFY);
   assign ident_read_end = ident_read_q && !ident_read;
   assign ie_sel = (i_host_addr == `UHF_ADDR_INTERRUPT_ENABLE) && !i_divisor_access_select;
   assign fc_write = wr_take && (i_host_addr == `UHF_ADDR_FIFO_CONTROL);
   assign ie_write = wr_take && ie_sel;

   assign rx_nonempty = (i_rx_count != {COUNT_W{1'b0}});
   assign tx_empty = (i_tx_count == {COUNT_W{1'b0}});
   assign tx_full = (i_tx_count >= FULL_COUNT);

   uhf_char_timeout u_char_timeout (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_fifo_mode(o_fifo_enable),
      .i_rx_nonempty(rx_nonempty),
      .i_rx_activity(i_rx_push | i_rx_pop),
      .i_char_tick(i_char_tick),
      .o_timeout(char_timeout)
   );

   always @* begin
      case (o_rx_trigger_sel)
         2'h0: trigger_bytes = `UHF_TRIG_LEVEL_0;
         2'h1: trigger_bytes = `UHF_TRIG_LEVEL_1;
         2'h2: trigger_bytes = `UHF_TRIG_LEVEL_2;
         2'h3: trigger_bytes = `UHF_TRIG_LEVEL_3;
         default: trigger_bytes = `UHF_TRIG_LEVEL_0;
      endcase
   end

   assign rx_at_trigger = ({{(8-COUNT_W){1'b0}}, i_rx_count} >= {3'h0, trigger_bytes});

   // Bus strobes are taken on their first cycle so a long access acts once.
   always @(posedge i_clk) begin
      if (i_reset) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         ident_read_q <= 1'b0;
      end else begin
         wr_q <= i_host_cs && i_host_wr;
         rd_q <= i_host_cs && i_host_rd;
         ident_read_q <= ident_read;
      end
   end

   always @(posedge i_clk) begin
      if (i_reset) begin
         interrupt_enable <= `UHF_IE_RESET;
      end else if (ie_write) begin
         interrupt_enable <= i_host_wdata[3:0];
      end
   end

   always @(posedge i_clk) begin
      if (i_reset) begin
         o_fifo_enable <= 1'b0;
         o_dma_mode <= 1'b0;
         o_rx_trigger_sel <= `UHF_TRIG_RESET;
         o_rx_fifo_clear <= 1'b0;
         o_tx_fifo_clear <= 1'b0;
      end else begin
         o_rx_fifo_clear <= 1'b0;
         o_tx_fifo_clear <= 1'b0;
         if (fc_write) begin
            o_fifo_enable <= i_host_wdata[`UHF_FC_ENABLE];
            if (!i_host_wdata[`UHF_FC_ENABLE]) begin
               // Leaving FIFO mode empties both FIFOs; the other bits are ignored.
               o_rx_fifo_clear <= 1'b1;
               o_tx_fifo_clear <= 1'b1;
               o_dma_mode <= 1'b0;
            end else begin
               o_dma_mode <= i_host_wdata[`UHF_FC_DMA];
               o_rx_trigger_sel <= i_host_wdata[`UHF_FC_TRIG_MSB:`UHF_FC_TRIG_LSB];
               o_rx_fifo_clear <= i_host_wdata[`UHF_FC_RX_RESET];
               o_tx_fifo_clear <= i_host_wdata[`UHF_FC_TX_RESET];
            end
         end
      end
   end

   // Status inputs are only observed here; their own registers are never gated.
   assign line_change = (i_line_status[4:1] != line_err_q);
   assign thre_rise = i_line_status[5] && !thre_q;

   always @(posedge i_clk) begin
      if (i_reset) begin
         line_err_q <= 4'h0;
         thre_q <= 1'b0;
         pend_line <= 1'b0;
         pend_tx <= 1'b0;
      end else begin
         line_err_q <= i_line_status[4:1];
         thre_q <= i_line_status[5];
         // A new change in the cycle of a line status read wins over the clear.
         if (line_change && interrupt_enable[`UHF_IE_LINE_STATUS]) begin
            pend_line <= 1'b1;
         end else if (i_line_status_read) begin
            pend_line <= 1'b0;
         end
         if (thre_rise && interrupt_enable[`UHF_IE_TX_EMPTY]) begin
            pend_tx <= 1'b1;
         end else if (ie_write && i_host_wdata[`UHF_IE_TX_EMPTY] &&
                      !interrupt_enable[`UHF_IE_TX_EMPTY] && i_line_status[5]) begin
            pend_tx <= 1'b1;
         end else if (i_tx_write || (ident_read_end && id_tx_reported)) begin
            pend_tx <= 1'b0;
         end
      end
   end

   assign src_line = pend_line && interrupt_enable[`UHF_IE_LINE_STATUS];
   assign src_rx = interrupt_enable[`UHF_IE_RX_DATA] &&
                   (o_fifo_enable ? rx_at_trigger : i_line_status[0]);
   assign src_timeout = interrupt_enable[`UHF_IE_RX_DATA] && char_timeout_q;
   assign src_tx = pend_tx && interrupt_enable[`UHF_IE_TX_EMPTY] &&
                   i_line_status[5];
   assign src_modem = interrupt_enable[`UHF_IE_MODEM_STATUS] &&
                      (|i_modem_status);
   assign any_pending = src_line | src_rx | src_timeout | src_tx | src_modem;

   always @* begin
      if (src_line) begin
         next_id = `UHF_ID_LINE_STATUS;
      end else if (src_timeout) begin
         next_id = `UHF_ID_CHAR_TIMEOUT;
      end else if (src_rx) begin
         next_id = `UHF_ID_RX_DATA;
      end else if (src_tx) begin
         next_id = `UHF_ID_TX_EMPTY;
      end else if (src_modem) begin
         next_id = `UHF_ID_MODEM_STATUS;
      end else begin
         next_id = `UHF_ID_NONE;
      end
   end

   // Interrupt state is held during an identification read and resumes afterwards.
   always @(posedge i_clk) begin
      if (i_reset) begin
         frozen_id <= `UHF_ID_NONE;
         frozen_none <= 1'b1;
         id_tx_reported <= 1'b0;
         o_host_interrupt_out <= 1'b0;
         char_timeout_q <= 1'b0;
      end else if (!ident_read) begin
         char_timeout_q <= char_timeout;
         frozen_id <= next_id;
         frozen_none <= !any_pending;
         o_host_interrupt_out <= any_pending;
         id_tx_reported <= 1'b0;
      end else if (rd_take) begin
         id_tx_reported <= !frozen_none && (frozen_id == `UHF_ID_TX_EMPTY);
      end
   end

   always @(posedge i_clk) begin
      if (i_reset) begin
         o_host_rdata <= 8'h00;
         o_host_rdata_sel <= 1'b0;
      end else if (rd_take) begin
         if (i_host_addr == `UHF_ADDR_INTERRUPT_IDENTIFY) begin
            o_host_rdata <= {o_fifo_enable, o_fifo_enable, 2'h0,
                             frozen_id[2] & o_fifo_enable, frozen_id[1:0],
                             frozen_none};
            o_host_rdata_sel <= 1'b1;
         end else if (ie_sel) begin
            o_host_rdata <= {4'h0, interrupt_enable};
            o_host_rdata_sel <= 1'b1;
         end else begin
            o_host_rdata <= 8'h00;
            o_host_rdata_sel <= 1'b0;
         end
      end else if (!(i_host_cs && i_host_rd)) begin
         o_host_rdata_sel <= 1'b0;
      end
   end

   always @* begin
      if (!o_fifo_enable) begin
         next_rx_dma = i_line_status[0];
         next_tx_dma = i_line_status[5];
      end else if (o_dma_mode) begin
         // The timeout flag lags the count by one cycle; qualify it so empty wins.
         if (rx_at_trigger || (char_timeout && rx_nonempty)) begin
            next_rx_dma = 1'b1;
         end else if (!rx_nonempty) begin
            next_rx_dma = 1'b0;
         end else begin
            next_rx_dma = o_receive_dma_request;
         end
         next_tx_dma = !tx_full;
      end else begin
         next_rx_dma = rx_nonempty;
         next_tx_dma = tx_empty;
      end
   end

   always @(posedge i_clk) begin
      if (i_reset) begin
         o_receive_dma_request <= 1'b0;
         o_transmit_dma_request <= 1'b0;
      end else begin
         o_receive_dma_request <= next_rx_dma;
         o_transmit_dma_request <= next_tx_dma;
      end
   end

endmodule

// ### test/uhf_props.sv
`timescale 1ns/100ps
module uhf_props #(
   parameter FIFO_DEPTH = 16,
   parameter COUNT_W = 5
) (
   // Ports of the block.
   input wire i_clk,
   input wire i_reset,
   input wire [2:0] i_host_addr,
   input wire i_host_cs,
   input wire i_host_rd,
   input wire i_host_wr,
   input wire [7:0] i_host_wdata,
   input wire i_divisor_access_select,
   input wire [COUNT_W-1:0] i_rx_count,
   input wire [COUNT_W-1:0] i_tx_count,
   input wire [7:0] o_host_rdata,
   input wire o_host_rdata_sel,
   input wire o_receive_dma_request,
   input wire o_transmit_dma_request,
   input wire o_fifo_enable,
   input wire o_dma_mode,
   input wire o_tx_fifo_clear
);
   default clocking @(posedge i_clk);
   endclocking
   default disable iff (i_reset);
   // Mode is trusted only across an edge with no bus access that could rewrite it.
   wire fd = !i_host_cs && o_fifo_enable && o_dma_mode;
   wire fn = !i_host_cs && o_fifo_enable && !o_dma_mode;
   sequence s_wr2;
      i_host_cs && i_host_wr && i_host_addr == 3'h2 && !$past(i_host_cs && i_host_wr);
   endsequence
   sequence s_rd(a);
      i_host_cs && i_host_rd && i_host_addr == a && !$past(i_host_cs && i_host_rd);
   endsequence
   a_tx_dma_free: assert property (fd && i_tx_count < FIFO_DEPTH
      |=> o_transmit_dma_request) else $error("tx request low with room");
   a_tx_plain: assert property (fn
      |=> o_transmit_dma_request == ($past(i_tx_count) == 0)) else $error("tx request wrong");
   a_rx_plain: assert property (fn
      |=> o_receive_dma_request == ($past(i_rx_count) != 0)) else $error("rx request wrong");
   a_rx_dma_empty: assert property (fd && i_rx_count == 0
      |=> !o_receive_dma_request) else $error("rx request high when empty");
   a_rx_dma_trig: assert property (fd && i_rx_count >= 5'h0E
      |=> o_receive_dma_request) else $error("rx request low above trigger");
   a_tx_clear_pulse: assert property (s_wr2 ##0 i_host_wdata[2]
      |=> o_tx_fifo_clear ##1 !o_tx_fifo_clear) else $error("tx clear not one pulse");
   a_ident_fixed: assert property (s_rd(3'h2) |=> o_host_rdata_sel
      && o_host_rdata[5:4] == 2'h0 && o_host_rdata[7:6] == {2{o_fifo_enable}}
      && (o_fifo_enable || !o_host_rdata[3])) else $error("identify fixed bits wrong");
   a_ie_upper: assert property (s_rd(3'h1) ##0 !i_divisor_access_select
      |=> o_host_rdata[7:4] == 4'h0) else $error("enable upper bits set");
endmodule

bind uhf_host_int_fifo_ctrl uhf_props #(.FIFO_DEPTH(FIFO_DEPTH), .COUNT_W(COUNT_W)) u_props (
   .i_clk, .i_reset, .i_host_addr, .i_host_cs, .i_host_rd, .i_host_wr, .i_host_wdata,
   .i_divisor_access_select, .i_rx_count, .i_tx_count, .o_host_rdata, .o_host_rdata_sel,
   .o_receive_dma_request, .o_transmit_dma_request, .o_fifo_enable, .o_dma_mode,
   .o_tx_fifo_clear);

// ### test/uhf_host_model.sv
`timescale 1ns/100ps
module uhf_host_model (
   // Host bus towards the block.
   input wire i_clk,
   output logic [2:0] o_addr,
   output logic o_cs,
   output logic o_rd,
   output logic o_wr,
   output logic [7:0] o_wdata,
   input wire [7:0] i_rdata
);
   // Released lines carry the inverse of their last value, so stale data never matches.
   initial {o_addr, o_wdata, o_cs, o_rd, o_wr} = 14'h0000;
   task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_clk);
      #1 {o_addr, o_wdata, o_cs, o_wr} = {a, d, 2'b11};
      @(posedge i_clk);
      #1 {o_addr, o_wdata, o_cs, o_wr} = {~a, ~d, 2'b00};
   endtask
   task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge i_clk);
      #1 {o_addr, o_cs, o_rd} = {a, 2'b11};
      @(posedge i_clk);
      @(posedge i_clk);
      d = i_rdata;
      #1 {o_addr, o_cs, o_rd} = {~a, 2'b00};
   endtask
endmodule

// ### test/tb.sv
`timescale 1ns/100ps
module tb;
   logic i_clk = 0;
   logic i_reset = 1;
   logic [5:0] ls = 0;
   logic [3:0] ms = 0;
   logic [4:0] rxc = 0, txc = 0, c;
   logic push = 0, pop = 0, das = 0, tick = 0, txw = 0, lsrd = 0, d, e;
   logic [7:0] v;
   logic [1:0] t;
   wire [2:0] addr;
   wire [7:0] wdata, rdata;
   wire cs, rd, wr, sel, irq, rxq, txq, fen, dma, rxclr, txclr;
   wire [1:0] trig;
   int num_errors = 0;
   int n_tests = 0;
   logic [3:0] code [4] = '{4'h4, 4'h2, 4'h6, 4'h0};
   logic [7:0] prio [4] = '{8'h06, 8'h04, 8'h02, 8'h00};
   initial forever #2 i_clk = ~i_clk;
   uhf_host_model host (.i_clk(i_clk), .o_addr(addr), .o_cs(cs), .o_rd(rd), .o_wr(wr),
      .o_wdata(wdata), .i_rdata(rdata));
   uhf_host_int_fifo_ctrl DUT (.i_clk(i_clk), .i_reset(i_reset), .i_host_addr(addr),
      .i_host_cs(cs), .i_host_rd(rd), .i_host_wr(wr), .i_host_wdata(wdata),
      .i_divisor_access_select(das), .o_host_rdata(rdata), .o_host_rdata_sel(sel),
      .i_line_status(ls), .i_line_status_read(lsrd), .i_modem_status(ms), .i_rx_count(rxc),
      .i_rx_push(push), .i_rx_pop(pop), .i_char_tick(tick), .i_tx_count(txc),
      .i_tx_write(txw), .o_host_interrupt_out(irq), .o_receive_dma_request(rxq),
      .o_transmit_dma_request(txq), .o_fifo_enable(fen), .o_dma_mode(dma),
      .o_rx_trigger_sel(trig), .o_rx_fifo_clear(rxclr), .o_tx_fifo_clear(txclr));
   task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
      n_tests++;
      if (got !== ex) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic pulse(ref logic p);
      p = 1;
      cyc(1);
      p = 0;
   endtask
   function automatic logic [4:0] lvl(input logic [1:0] s);
      return s == 0 ? 5'h01 : s == 1 ? 5'h04 : s == 2 ? 5'h08 : 5'h0E;
   endfunction
   task automatic src(input int s, input logic on);
      case (s)
         0: ls[0] = on;
         1: ls[5] = on;
         2: ls[4:1] = on ? 4'h1 << $urandom_range(3) : 4'h0;
         default: ms = on ? 4'h1 << $urandom_range(3) : 4'h0;
      endcase
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #100000;
      num_errors++;
      tally_and_finish;
   end
   initial begin
      void'($urandom(74));
      cyc(5);
      i_reset = 0;
      host.bus_rd(3'h1, v);
      chk("ie_reset", 8'h00, v);
      host.bus_rd(3'h2, v);
      chk("ident_idle", 8'h01, v);
      chk("ident_sel", 1, sel);
      host.bus_wr(3'h1, 8'hFF);
      host.bus_rd(3'h1, v);
      chk("ie_upper", 8'h0F, v);
      das = 1;
      host.bus_rd(3'h1, v);
      chk("ie_hidden", 8'h00, v);
      chk("ie_hidden_sel", 0, sel);
      das = 0;
      $display("register test done");
      for (int s = 0; s < 4; s++) begin
         host.bus_wr(3'h1, 8'h00);
         ls = 0;
         ms = 0;
         cyc(2);
         src(s, 1);
         cyc(3);
         chk("irq_disabled", 0, irq);
         host.bus_rd(3'h2, v);
         chk("ident_disabled", 8'h01, v);
         src(s, 0);
         host.bus_wr(3'h1, 8'h01 << s);
         src(s, 1);
         cyc(3);
         chk("irq_enabled", 1, irq);
         host.bus_rd(3'h2, v);
         chk("ident_source", {4'h0, code[s]}, v);
         if (s == 2)
            pulse(lsrd);
         else if (s != 1)
            src(s, 0);
         cyc(3);
         chk("irq_cleared", 0, irq);
      end
      host.bus_wr(3'h1, 8'h0F);
      ls = 6'h23;
      ms = 4'h1;
      for (int i = 0; i < 4; i++) begin
         cyc(3);
         host.bus_rd(3'h2, v);
         chk("ident_priority", prio[i], v);
         if (i == 0)
            pulse(lsrd);
         ls[0] = (i == 0);
      end
      ms = 0;
      ls[5] = 0;
      cyc(2);
      ls[5] = 1;
      cyc(3);
      chk("irq_tx", 1, irq);
      pulse(txw);
      cyc(3);
      chk("irq_tx_write", 0, irq);
      host.bus_wr(3'h1, 8'h00);
      $display("interrupt tests done");
      for (int k = 0; k < 12; k++) begin
         t = $urandom_range(3);
         d = k < 2 ? 1'b1 : 1'($urandom_range(1));
         c = k == 0 ? 5'h10 : k == 1 ? 5'h0E : k == 2 ? lvl(t) : 5'($urandom_range(16));
         host.bus_wr(3'h2, {t, 2'b00, d, 3'b001});
         chk("mode", {4'h0, 1'b1, d, t}, {4'h0, fen, dma, trig});
         rxc = c;
         txc = c;
         e = d ? c >= lvl(t) : c != 0;
         cyc(2);
         chk("rx_request", e, rxq);
         chk("tx_request", d ? c < 5'h10 : c == 0, txq);
         rxc = 1;
         cyc(2);
         chk("rx_request_held", e | !d | (t == 2'h0), rxq);
         rxc = 0;
         cyc(2);
         chk("rx_request_empty", 0, rxq);
      end
      host.bus_wr(3'h2, {~t, 6'h0E});
      chk("fc_off", {6'h00, t}, {4'h0, fen, dma, trig});
      chk("clears_off", 2'b11, {rxclr, txclr});
      host.bus_wr(3'h2, 8'h07);
      chk("clears_both", 2'b11, {rxclr, txclr});
      host.bus_wr(3'h2, 8'h03);
      chk("clears_rx", 2'b10, {rxclr, txclr});
      $display("fifo tests done");
      txc = 0;
      host.bus_wr(3'h1, 8'h01);
      rxc = 1;
      pulse(push);
      cyc(2);
      host.bus_rd(3'h2, v);
      chk("ident_rx_fifo", 8'hC4, v);
      repeat (3) begin
         pulse(tick);
         cyc(1);
      end
      pulse(pop);
      repeat (3) begin
         pulse(tick);
         cyc(1);
      end
      host.bus_rd(3'h2, v);
      chk("ident_pop_restart", 8'hC4, v);
      repeat (2) begin
         pulse(tick);
         cyc(1);
      end
      cyc(1);
      host.bus_rd(3'h2, v);
      chk("ident_timeout", 8'hCC, v);
      chk("irq_timeout", 1, irq);
      $display("timeout test done");
      tally_and_finish;
   end
endmodule
